// ===== inc/sfesp_pkg.sv
package sfesp_pkg;
  // opcodes named here; the core decodes only ten of them
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_SECREG_ERASE = 8'h44;
  localparam logic [7:0] OP_STATUS_WR1 = 8'h01;
  localparam logic [7:0] OP_STATUS_WR2 = 8'h31;
  localparam logic [7:0] OP_STATUS_WR3 = 8'h11;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECREG_PROG = 8'h42;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  // frame lengths in serial bits
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
  // clock and times
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  localparam int RESUME_BUSY_NS = 200;
  localparam int RESUME_BUSY_CYC = (RESUME_BUSY_NS / SYS_PERIOD_NS) < 1 ? 1 :
                                   (RESUME_BUSY_NS / SYS_PERIOD_NS);
  // kinds of background operation
  typedef enum logic [1:0] {SFESP_OP_NONE, SFESP_OP_ERASE, SFESP_OP_CHIP, SFESP_OP_PROG}
    sfesp_op_e;
endpackage : sfesp_pkg

// ===== hdl/sfesp_core.sv
`timescale 1ns/1ps
module sfesp_core import sfesp_pkg::*; #(
  parameter int SMALL_BLOCK_ERASE_CYC = 100_000,
  parameter int LARGE_BLOCK_ERASE_CYC = 200_000,
  parameter int FULL_ARRAY_ERASE_CYC = 1_000_000,
  parameter int PROGRAM_CYC = 4_000,
  parameter int SUSPEND_LATENCY_CYC = 200,
  parameter int POWERDOWN_ENTRY_CYC = 30,
  parameter int WAKE_RELEASE_CYC = 30
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // serial link pins from the host
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_in_line,
  // status bits shown to the status read path
  output logic busy,
  output logic write_enable_latch,
  output logic suspend_flag,
  output logic powered_down,
  // protection lookup from the protection block
  input wire logic target_protected,
  input wire logic any_protected,
  output logic [23:0] target_addr,
  // program operation started elsewhere
  input wire logic program_start,
  // array erase strobes to the array control
  output logic erase_start,
  output logic [1:0] erase_kind,
  output logic erase_done,
  // command seen and executed in this core
  output logic status_read_ok
);
  localparam int CNT_W = 24;
  // two-flop synchronisers for the pins
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] si_sync;
  logic cs_prev; // last synchronised chip select
  logic sck_prev; // last synchronised serial clock
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      si_sync <= 2'h0;
      cs_prev <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], chip_select_n};
      sck_sync <= {sck_sync[0], serial_clk};
      si_sync <= {si_sync[0], serial_in_line};
      cs_prev <= cs_sync[1];
      sck_prev <= sck_sync[1];
    end
  end
  // edges of the synchronised pins
  wire cs_low = ~cs_sync[1];
  wire cs_rise = cs_sync[1] & ~cs_prev;
  wire cs_fall = ~cs_sync[1] & cs_prev;
  wire sck_rise = sck_sync[1] & ~sck_prev & cs_low;

  // shift register and bit counter for one frame
  logic [31:0] shreg;
  logic [5:0] bitcnt;
  logic overrun; // more bits than any command here needs
  always_ff @(posedge sys_clk) begin
    if (reset || cs_fall) begin
      shreg <= 32'h0;
      bitcnt <= 6'h0;
      overrun <= 1'b0;
    end else if (sck_rise) begin
      shreg <= {shreg[30:0], si_sync[1]};
      if (bitcnt == BITS_ADDR_CMD) overrun <= 1'b1;
      else bitcnt <= bitcnt + 6'h1;
    end
  end

  // frame decode at the rising edge of chip select
  wire len8 = (bitcnt == BITS_OPCODE) & ~overrun;
  wire len32 = (bitcnt == BITS_ADDR_CMD) & ~overrun;
  wire [7:0] op8 = shreg[7:0];
  wire [7:0] op32 = shreg[31:24];
  wire is_blk32 = len32 & (op32 == OP_BLK32_ERASE);
  wire is_blk64 = len32 & (op32 == OP_BLK64_ERASE);
  wire is_chip = len8 & ((op8 == OP_CHIP_ERASE_A) | (op8 == OP_CHIP_ERASE_B));
  wire is_wren = len8 & (op8 == OP_WRITE_EN);
  wire is_susp = len8 & (op8 == OP_SUSPEND);
  wire is_resm = len8 & (op8 == OP_RESUME);
  wire is_pdn = len8 & (op8 == OP_POWER_DOWN);
  wire is_wake = len8 & (op8 == OP_WAKE);

  // state of the background operation
  sfesp_op_e cur_op; // operation running or suspended
  logic [CNT_W-1:0] op_left; // cycles of operation still to run
  logic [CNT_W-1:0] sus_cnt; // suspend latency countdown
  logic [CNT_W-1:0] res_cnt; // resume busy delay countdown
  logic [CNT_W-1:0] pd_cnt; // power-down entry and wake release countdown
  logic pd_pending; // power-down entry in progress
  logic waking; // wake release time running
  logic running; // the array is actively working

  // gates applied before any command except wake is taken
  wire can_cmd = ~powered_down & ~pd_pending & ~waking;
  wire erase_susp = suspend_flag & (cur_op == SFESP_OP_ERASE);
  wire prog_susp = suspend_flag & (cur_op == SFESP_OP_PROG);
  wire erase_barred = erase_susp | prog_susp; // erasing always blocked while suspended
  wire idle = ~busy & ~suspend_flag;
  wire erase_ok = cs_rise & can_cmd & idle & ~erase_barred & write_enable_latch;
  wire go_blk32 = erase_ok & is_blk32 & ~target_protected;
  wire go_blk64 = erase_ok & is_blk64 & ~target_protected;
  wire go_chip = erase_ok & is_chip & ~any_protected;
  wire go_erase = go_blk32 | go_blk64 | go_chip;
  wire go_susp = cs_rise & can_cmd & is_susp & busy & ~suspend_flag & (res_cnt == '0)
                 & ((cur_op == SFESP_OP_ERASE) | (cur_op == SFESP_OP_PROG));
  wire go_resm = cs_rise & can_cmd & is_resm & suspend_flag & ~busy;
  wire go_pdn = cs_rise & can_cmd & is_pdn & ~busy;
  wire go_wake = cs_rise & powered_down & is_wake;
  wire go_prog = program_start & can_cmd & idle & ~prog_susp;
  wire op_end = running & (op_left == '0);

  // cycles for the erase that starts now
  wire [CNT_W-1:0] erase_len = go_chip ? CNT_W'(FULL_ARRAY_ERASE_CYC) :
                               go_blk64 ? CNT_W'(LARGE_BLOCK_ERASE_CYC) :
                               CNT_W'(SMALL_BLOCK_ERASE_CYC);

  // operation tracking and timers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cur_op <= SFESP_OP_NONE; // lost operation forgotten
      op_left <= '0;
      running <= 1'b0;
    end else if (go_erase) begin
      cur_op <= go_chip ? SFESP_OP_CHIP : SFESP_OP_ERASE;
      op_left <= erase_len - CNT_W'(1);
      running <= 1'b1;
    end else if (go_prog) begin
      cur_op <= SFESP_OP_PROG;
      op_left <= CNT_W'(PROGRAM_CYC) - CNT_W'(1);
      running <= 1'b1;
    end else if (go_susp) begin
      running <= 1'b0; // remaining count is kept for the resume
    end else if (res_cnt == CNT_W'(1)) begin
      running <= 1'b1;
    end else if (op_end) begin
      cur_op <= SFESP_OP_NONE;
      running <= 1'b0;
    end else if (running) begin
      op_left <= op_left - CNT_W'(1);
    end
  end

  // suspend latency and resume delay counters
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sus_cnt <= '0;
      res_cnt <= '0;
    end else begin
      if (go_susp) sus_cnt <= CNT_W'(SUSPEND_LATENCY_CYC);
      else if (sus_cnt != '0) sus_cnt <= sus_cnt - CNT_W'(1);
      if (go_resm) res_cnt <= CNT_W'(RESUME_BUSY_CYC);
      else if (res_cnt != '0) res_cnt <= res_cnt - CNT_W'(1);
    end
  end

  // busy and suspend flags
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy <= 1'b0;
      suspend_flag <= 1'b0;
    end else begin
      if (go_erase || go_prog) busy <= 1'b1;
      else if (op_end) busy <= 1'b0;
      else if (sus_cnt == CNT_W'(1)) busy <= 1'b0; // dropped at end of latency
      else if (res_cnt == CNT_W'(1)) busy <= 1'b1;
      if (go_susp) suspend_flag <= 1'b1;
      else if (go_resm) suspend_flag <= 1'b0;
    end
  end

  // write enable latch
  always_ff @(posedge sys_clk) begin
    if (reset) write_enable_latch <= 1'b0;
    else if (op_end) write_enable_latch <= 1'b0;
    else if (cs_rise && can_cmd && is_wren) write_enable_latch <= 1'b1;
  end

  // power-down entry and wake release
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      powered_down <= 1'b0;
      pd_pending <= 1'b0;
      waking <= 1'b0;
      pd_cnt <= '0;
    end else if (go_pdn) begin
      pd_pending <= 1'b1;
      pd_cnt <= CNT_W'(POWERDOWN_ENTRY_CYC);
    end else if (go_wake) begin
      powered_down <= 1'b0;
      waking <= 1'b1;
      pd_cnt <= CNT_W'(WAKE_RELEASE_CYC);
    end else if (pd_cnt != CNT_W'(1) && pd_cnt != '0) begin
      pd_cnt <= pd_cnt - CNT_W'(1);
    end else if (pd_cnt == CNT_W'(1)) begin
      pd_cnt <= '0;
      if (pd_pending) powered_down <= 1'b1;
      pd_pending <= 1'b0;
      waking <= 1'b0;
    end
  end

  // outputs towards array control
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      target_addr <= 24'h0;
      erase_start <= 1'b0;
      erase_kind <= 2'h0;
      erase_done <= 1'b0;
      status_read_ok <= 1'b0;
    end else begin
      if (cs_low && len32) target_addr <= shreg[23:0];
      erase_start <= go_erase;
      if (go_erase) erase_kind <= go_chip ? 2'h2 : (go_blk64 ? 2'h1 : 2'h0);
      erase_done <= op_end & (cur_op != SFESP_OP_PROG);
      // status read seen on its eighth bit; allowed unless powered down, entering power-down or waking
      // one pulse on the completing clock edge, not a level for the rest of the frame
      status_read_ok <= sck_rise & ~overrun & (bitcnt == BITS_OPCODE - 6'h1)
                        & ({shreg[6:0], si_sync[1]} == OP_STATUS_RD) & can_cmd;
    end
  end
endmodule : sfesp_core

// ===== dv/sfesp_props.sv
`timescale 1ns/1ps
// watches the status bits and erase strobes of the core
module sfesp_props import sfesp_pkg::*; #(
  parameter int SUSPEND_LATENCY_CYC = 200
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // status and strobes
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic suspend_flag,
  input wire logic powered_down,
  input wire logic erase_start,
  input wire logic erase_done,
  input wire logic status_read_ok
);
  // slack of two cycles for the flag landing after the command
  localparam int SUS_MAX = SUSPEND_LATENCY_CYC + 2;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_start_sets_busy: assert property (erase_start |=> busy)
    else $error("busy not set after erase start");
  a_start_needs_wel: assert property (erase_start |-> write_enable_latch)
    else $error("erase started without write enable");
  a_start_not_held: assert property (erase_start |-> !suspend_flag && !powered_down)
    else $error("erase started while suspended or asleep");
  a_done_clears_wel: assert property (erase_done |-> ##[0:1] !busy && !write_enable_latch)
    else $error("write enable or busy left after erase");
  a_suspend_needs_busy: assert property ($rose(suspend_flag) |-> $past(busy))
    else $error("suspend taken while idle");
  a_suspend_drops_busy: assert property ($rose(suspend_flag) |-> ##[0:SUS_MAX] !busy)
    else $error("busy not dropped within suspend latency");
  a_resume_sets_busy: assert property ($fell(suspend_flag) |-> ##[0:2] busy)
    else $error("busy not back after resume");
  a_sleep_is_mute: assert property (powered_down |-> !erase_start && !status_read_ok)
    else $error("command acted on while powered down");
  a_reset_normal: assert property ($fell(reset) |-> !powered_down && !suspend_flag)
    else $error("not in normal state after reset");
endmodule : sfesp_props
bind sfesp_core sfesp_props #(.SUSPEND_LATENCY_CYC(SUSPEND_LATENCY_CYC)) sfesp_props_i (.*);

// ===== dv/sfesp_host.sv
`timescale 1ns/1ps
// host end of the serial link, one command per frame
module sfesp_host (
  // serial link pins
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_in_line
);
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in_line = 1'b1;
  end
  // clock stands low between frames; a short count gives a bad release
  task automatic send(input logic [31:0] word, input int nbits);
    chip_select_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in_line = word[i];
      #400 serial_clk = 1'b1;
      #400 serial_clk = 1'b0;
    end
    #400 chip_select_n = 1'b1;
    serial_in_line = ~serial_in_line; // released line never shows the last bit
  endtask : send
endmodule : sfesp_host

// ===== dv/sfesp_core_tb.sv
`timescale 1ns/1ps
module sfesp_core_tb import sfesp_pkg::*; ;
  logic sys_clk, reset = 1'b1, target_protected = 1'b0, any_protected = 1'b0;
  logic program_start = 1'b0;
  wire chip_select_n, serial_clk, serial_in_line;
  logic busy, write_enable_latch, suspend_flag, powered_down, erase_start, erase_done;
  logic status_read_ok;
  logic [1:0] erase_kind;
  logic [23:0] target_addr;
  int err_count = 0, n_tests = 0, reads = 0;
  logic [31:0] seed = 32'h898e175d;
  logic [25:0] notes[$]; // kind and address of each erase still owed
  logic [7:0] ops[4] = '{OP_BLK32_ERASE, OP_BLK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
  sfesp_host sfesp_host_i (.chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_in_line(serial_in_line));
  // short counts keep the whole run small
  sfesp_core #(.SMALL_BLOCK_ERASE_CYC(150), .LARGE_BLOCK_ERASE_CYC(200),
    .FULL_ARRAY_ERASE_CYC(250), .PROGRAM_CYC(300),
    .SUSPEND_LATENCY_CYC(60)) sfesp_core_i (.sys_clk(sys_clk),
    .reset(reset), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_in_line(serial_in_line), .busy(busy), .write_enable_latch(write_enable_latch),
    .suspend_flag(suspend_flag), .powered_down(powered_down),
    .target_protected(target_protected), .any_protected(any_protected),
    .target_addr(target_addr), .program_start(program_start), .erase_start(erase_start),
    .erase_kind(erase_kind), .erase_done(erase_done), .status_read_ok(status_read_ok));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // one frame, then time for the sync pipeline and the answer
  task automatic cmd(input logic [31:0] w, input int n);
    tick(1);
    sfesp_host_i.send(w, n);
    tick(6);
  endtask : cmd
  // bounded wait; running out ends the run
  task automatic wait_busy(input logic val);
    int k;
    for (k = 0; k < 400 && busy !== val; k++) tick(1);
    if (k == 400) begin
      err_count++;
      stop_test();
    end
  endtask : wait_busy
  task automatic erase(input logic [7:0] op, input logic [1:0] kind);
    logic [23:0] a;
    seed = lfsr(seed);
    a = seed[23:0];
    cmd({24'h0, OP_WRITE_EN}, 8);
    check("wel", write_enable_latch, 1);
    notes.push_back({kind, a});
    if (kind == 2'h2) cmd({24'h0, op}, 8);
    else cmd({op, a}, 32);
  endtask : erase
  // second process: every erase strobe is matched to the oldest note
  always @(posedge sys_clk) begin
    if (erase_start === 1'b1) begin
      if (notes.size() == 0) check("stray erase", 1, 0);
      else begin
        check("kind", erase_kind, notes[0][25:24]);
        if (notes[0][25:24] != 2'h2) check("addr", target_addr, notes[0][23:0]);
        void'(notes.pop_front());
      end
    end
    if (status_read_ok === 1'b1) reads++;
  end
  initial begin
    int r;
    repeat (6) @(posedge sys_clk);
    #1 reset = 1'b0;
    tick(4);
    check("pd", powered_down, 0);
    cmd({OP_BLK32_ERASE, 24'h0}, 32);
    check("busy", busy, 0);
    for (int i = 0; i < 4; i++) begin
      erase(ops[i], (i < 2) ? 2'(i) : 2'h2);
      check("busy", busy, 1);
      cmd({24'h0, OP_STATUS_RD}, 8);
      wait_busy(1'b0);
      check("wel", write_enable_latch, 0);
    end
    check("reads", 24'(reads), 4);
    cmd({24'h0, OP_WRITE_EN}, 8);
    cmd({OP_BLK64_ERASE, 24'h0}, 31);
    check("busy", busy, 0);
    target_protected = 1'b1;
    any_protected = 1'b1;
    cmd({OP_BLK32_ERASE, 24'h0}, 32);
    cmd({24'h0, OP_CHIP_ERASE_A}, 8);
    check("busy", busy, 0);
    target_protected = 1'b0;
    any_protected = 1'b0;
    cmd({24'h0, OP_SUSPEND}, 8);
    check("sus", suspend_flag, 0);
    erase(OP_BLK64_ERASE, 2'h1);
    cmd({24'h0, OP_SUSPEND}, 8);
    check("sus", suspend_flag, 1);
    wait_busy(1'b0);
    cmd({OP_BLK32_ERASE, 24'h0}, 32);
    check("busy", busy, 0);
    cmd({24'h0, OP_RESUME}, 8);
    check("sus", suspend_flag, 0);
    check("busy", busy, 1);
    wait_busy(1'b0);
    erase(OP_CHIP_ERASE_A, 2'h2);
    cmd({24'h0, OP_SUSPEND}, 8);
    check("sus", suspend_flag, 0);
    wait_busy(1'b0);
    // a program run is suspendable and resumable as well
    program_start = 1'b1;
    tick(1);
    program_start = 1'b0;
    check("busy", busy, 1);
    cmd({24'h0, OP_SUSPEND}, 8);
    check("sus", suspend_flag, 1);
    wait_busy(1'b0);
    cmd({24'h0, OP_RESUME}, 8);
    check("sus", suspend_flag, 0);
    wait_busy(1'b0);
    cmd({24'h0, OP_POWER_DOWN}, 8);
    tick(40);
    check("pd", powered_down, 1);
    r = reads;
    cmd({24'h0, OP_STATUS_RD}, 8);
    check("reads", 24'(reads), 24'(r));
    cmd({24'h0, OP_WAKE}, 8);
    tick(40);
    check("pd", powered_down, 0);
    erase(OP_BLK64_ERASE, 2'h1);
    cmd({24'h0, OP_SUSPEND}, 8);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(4);
    check("sus", suspend_flag, 0);
    cmd({24'h0, OP_RESUME}, 8);
    check("busy", busy, 0);
    check("pending", 24'(notes.size()), 0);
    stop_test();
  end
endmodule : sfesp_core_tb
